// File: etc_pkg.sv
// constants, codes and carrier types for the exception and trap sequencer
package etc_pkg;

  // ------------------------------------------------------------------
  // sizes and timing
  // ------------------------------------------------------------------
  localparam int          NUM_IRQ      = 4;
  localparam int          PRIO_W       = 3;
  localparam int          STAT_W       = 8;
  localparam int          CLK_PERIOD_NS = 100;
  localparam logic [2:0]  LAT_MIN_CYC  = 3'h4;   // latency, internal clock cycles
  localparam logic [2:0]  LAT_MAX_CYC  = 3'h6;

  // ------------------------------------------------------------------
  // status word bit positions and reset value
  // ------------------------------------------------------------------
  localparam int          STAT_ID      = 0;
  localparam int          STAT_EP      = 1;
  localparam int          STAT_NP      = 2;
  localparam logic [7:0]  STATUS_RESET = 8'h01;

  // ------------------------------------------------------------------
  // vectors, codes and illegal opcode pattern
  // ------------------------------------------------------------------
  localparam logic [31:0] VEC_TRAP_LO  = 32'h0000_0040;
  localparam logic [31:0] VEC_TRAP_HI  = 32'h0000_0050;
  localparam logic [31:0] VEC_DEBUG    = 32'h0000_0060;
  localparam logic [31:0] VEC_IRQ_BASE = 32'h0000_0100;
  localparam logic [15:0] TRAP_CODE_BASE = 16'h0040;
  localparam logic [15:0] IRQ_CODE_BASE  = 16'h0080;
  localparam logic [5:0]  ILG_OPCODE   = 6'h3f;
  localparam logic [3:0]  ILG_SUB_MIN  = 4'h7;

  // ------------------------------------------------------------------
  // register byte offsets and reset values
  // ------------------------------------------------------------------
  localparam logic [7:0]  OFF_STATUS     = 8'h00;
  localparam logic [7:0]  OFF_EXC_PC     = 8'h04;
  localparam logic [7:0]  OFF_EXC_STAT   = 8'h08;
  localparam logic [7:0]  OFF_EXC_CAUSE  = 8'h0c;
  localparam logic [7:0]  OFF_DBG_PC     = 8'h10;
  localparam logic [7:0]  OFF_DBG_STAT   = 8'h14;
  localparam logic [7:0]  OFF_IRQ_STATE  = 8'h18;
  localparam logic [7:0]  OFF_IRQ_CTRL0  = 8'h20;
  localparam int          CTRL_MASK_BIT  = 6;
  localparam int          CTRL_PEND_BIT  = 7;
  localparam logic [2:0]  PRIO_RESET     = 3'h7;
  localparam logic        MASK_RESET     = 1'b1;

  // ------------------------------------------------------------------
  // carrier types
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    ETC_K_NONE, ETC_K_TRAP, ETC_K_EXC_RETURN_INSTR, ETC_K_DEBUG_BREAK_INSTR, ETC_K_DEBUG_RETURN_INSTR
  } etc_kind_e;

  typedef struct packed {
    logic        valid;      // instruction executes this cycle
    etc_kind_e   kind;
    logic [4:0]  vector;     // software exception operand
    logic [31:0] word;       // raw instruction word
    logic [31:0] return_pc;  // pc to resume at afterwards
    logic        long_op;    // long-latency instruction in progress
    logic        nonsample;  // interrupt request non-sample instruction
  } etc_issue_s;

  typedef struct packed {
    logic        valid;
    logic        flush;
    logic [31:0] pc;
  } etc_redirect_s;

endpackage

// File: etc_irq_slot.sv
// one maskable request source: pending latch, mask bit and priority field
`timescale 1ns/1ps
module etc_irq_slot
  import etc_pkg::*;
(
  input  logic              clock,
  input  logic              rst,
  input  logic              req,
  input  logic              ack,
  input  logic              wr_en,
  input  logic [7:0]        wdata,
  output logic              pend,
  output logic              mask,
  output logic [PRIO_W-1:0] prio
);

  // ------------------------------------------------------------------
  // control fields, software owned
  // ------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      mask <= MASK_RESET;
      prio <= PRIO_RESET;
    end else if (wr_en) begin
      mask <= wdata[CTRL_MASK_BIT];
      prio <= wdata[PRIO_W-1:0];
    end
  end

  // pending latch; a new request beats both ack and software clear
  always_ff @(posedge clock) begin
    if (rst) begin
      pend <= 1'b0;
    end else if (req) begin
      pend <= 1'b1;
    end else if (ack || (wr_en && !wdata[CTRL_PEND_BIT])) begin
      pend <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  // first edge after release; the very first edge has no reset history yet
  chk_reset_mask_prio: assert property (@(posedge clock) $past(rst) && !rst |-> mask && prio == 3'h7)
    else $error("slot not masked at level 7 after reset");

endmodule // etc_irq_slot

// File: etc_trap_ctrl.sv
// exception, trap and nested maskable interrupt sequencer with register slave
`timescale 1ns/1ps
// How it works
// - trap instruction always enters its exception, nothing masks it
// - trap entry saves resume pc and status into exception save registers
// - trap entry writes a code into low 16 bits of cause register
// - trap entry sets exception-active and interrupt-disable flags
// - vector 00-0f goes to 0x40, vector 10-1f goes to 0x50
// - exception return reloads pc and status from exception save registers
// - illegal opcode: bits 10..5 all ones, 26..23 in 7..f, bit 16 zero
// - illegal opcode saves to debug registers, sets three flags, jumps 0x60
// - debug break always taken, saves to debug registers, jumps 0x60
// - debug return reloads pc and status from debug save registers
// - debug save registers reachable only inside a debug trap window
// - higher priority request preempts service, lower one stays pending
// - nested maskable acknowledge only while interrupt-disable flag is zero
// - each request has a 3-bit priority, 0 highest, 7 lowest
// - after reset every request is masked and at priority 7
// - suspended or pending requests proceed only after exception return
// - while non-maskable service runs, maskable requests stay pending
// - interrupt latency is 4 cycles minimum, 6 maximum
// - long-latency instructions in flight push latency to the maximum
// - no acknowledge between a non-sample instruction and the next one
module etc_trap_ctrl
  import etc_pkg::*;
(
  input  logic               clock,
  input  logic               rst,
  input  etc_issue_s         issue,
  input  logic [NUM_IRQ-1:0] irq_req,
  input  logic [7:0]         avs_address,
  input  logic               avs_read,
  input  logic               avs_write,
  input  logic [31:0]        avs_writedata,
  input  logic [3:0]         avs_byteenable,
  output logic [31:0]        avs_readdata,
  output logic               avs_waitrequest,
  output etc_redirect_s      redirect,
  output logic [STAT_W-1:0]  status_word
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  logic [31:0]        exc_return_pc;
  logic [STAT_W-1:0]  exc_saved_status;
  logic [31:0]        exc_cause_reg;
  logic [31:0]        dbg_return_pc;
  logic [STAT_W-1:0]  dbg_saved_status;
  logic               dbg_window_reg;
  logic               shadow_reg;
  logic [7:0]         isr_reg;
  logic [2:0]         lat_cnt_reg;
  logic               long_seen_reg;
  logic               ack_reg;
  logic [NUM_IRQ-1:0] slot_pend;
  logic [NUM_IRQ-1:0] slot_mask;
  logic [PRIO_W-1:0]  slot_prio [NUM_IRQ];
  logic [NUM_IRQ-1:0] slot_ack;
  logic [NUM_IRQ-1:0] slot_wr;

  // ------------------------------------------------------------------
  // instruction decode
  // ------------------------------------------------------------------
  logic issue_ok, illegal, is_trap, is_exc_return_instr, is_debug_break_instr, is_debug_return_instr, dbg_entry, exc_event;
  logic wr_en;

  // instructions issued in the redirect cycle are dead and are dropped
  assign issue_ok  = issue.valid && !redirect.valid;
  assign illegal   = issue_ok && issue.word[10:5] == ILG_OPCODE &&
                     issue.word[26:23] >= ILG_SUB_MIN && !issue.word[16];
  assign is_trap   = issue_ok && !illegal && issue.kind == ETC_K_TRAP;
  assign is_exc_return_instr   = issue_ok && !illegal && issue.kind == ETC_K_EXC_RETURN_INSTR;
  assign is_debug_break_instr = issue_ok && !illegal && issue.kind == ETC_K_DEBUG_BREAK_INSTR;
  assign is_debug_return_instr  = issue_ok && !illegal && issue.kind == ETC_K_DEBUG_RETURN_INSTR;
  assign dbg_entry = illegal || is_debug_break_instr;
  assign exc_event = is_trap || is_exc_return_instr || dbg_entry || is_debug_return_instr;
  assign wr_en     = avs_write && ack_reg;

  // ------------------------------------------------------------------
  // request arbitration
  // ------------------------------------------------------------------
  logic        best_valid;
  logic [1:0]  best_idx;
  logic [3:0]  best_prio;
  logic [3:0]  cur_level;
  logic        eligible;
  logic        irq_fire;
  logic [2:0]  lat_target;

  // lowest priority number wins, lower index breaks ties
  always_comb begin
    best_valid = 1'b0;
    best_idx   = 2'h0;
    best_prio  = 4'h8;
    for (int i = 0; i < NUM_IRQ; i++) begin
      if (slot_pend[i] && !slot_mask[i] && {1'b0, slot_prio[i]} < best_prio) begin
        best_valid = 1'b1;
        best_idx   = 2'(i);
        best_prio  = {1'b0, slot_prio[i]};
      end
    end
  end

  // level in service is the lowest set in-service bit, 8 when idle
  always_comb begin
    cur_level = 4'h8;
    for (int l = 7; l >= 0; l--) begin
      if (isr_reg[l]) begin
        cur_level = 4'(l);
      end
    end
  end

  // only a strictly higher level may preempt; equal or lower waits for return
  assign eligible = best_valid && best_prio < cur_level &&
                    !status_word[STAT_ID] &&
                    !status_word[STAT_NP] &&
                    !shadow_reg && !(issue_ok && issue.nonsample) &&
                    !exc_event && !redirect.valid;
  assign lat_target = (long_seen_reg || (issue_ok && issue.long_op)) ?
                      LAT_MAX_CYC - 3'h1 : LAT_MIN_CYC - 3'h1;
  assign irq_fire   = eligible && lat_cnt_reg >= lat_target;

  always_comb begin
    slot_ack = '0;
    slot_ack[best_idx] = irq_fire;
  end

  // latency counter restarts whenever the winner loses eligibility
  always_ff @(posedge clock) begin
    if (rst || !eligible || irq_fire) begin
      lat_cnt_reg   <= 3'h0;
      long_seen_reg <= 1'b0;
    end else begin
      lat_cnt_reg   <= lat_cnt_reg + 3'h1;
      long_seen_reg <= long_seen_reg || (issue_ok && issue.long_op);
    end
  end

  // acknowledge blocked until the instruction after a non-sample one
  always_ff @(posedge clock) begin
    if (rst) begin
      shadow_reg <= 1'b0;
    end else if (issue_ok) begin
      shadow_reg <= issue.nonsample;
    end
  end

  // in-service levels; maskable return pops the innermost one
  always_ff @(posedge clock) begin
    if (rst) begin
      isr_reg <= 8'h00;
    end else if (irq_fire) begin
      isr_reg <= isr_reg | (8'h01 << best_prio[2:0]);
    end else if (is_exc_return_instr && !status_word[STAT_EP]) begin
      isr_reg <= isr_reg & (isr_reg - 8'h01);
    end
  end

  // ------------------------------------------------------------------
  // request slots
  // ------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_IRQ; g++) begin : g_slot
      assign slot_wr[g] = wr_en && avs_byteenable[0] &&
                          avs_address == OFF_IRQ_CTRL0 + 8'(4 * g);
      etc_irq_slot u_slot (
        .clock (clock),
        .rst   (rst),
        .req   (irq_req[g]),
        .ack   (slot_ack[g]),
        .wr_en (slot_wr[g]),
        .wdata (avs_writedata[7:0]),
        .pend  (slot_pend[g]),
        .mask  (slot_mask[g]),
        .prio  (slot_prio[g])
      );
    end
  endgenerate

  // ------------------------------------------------------------------
  // status word and save registers
  // ------------------------------------------------------------------
  function automatic logic [31:0] be_merge(logic [31:0] old_v, logic [31:0] new_v,
                                           logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  // hardware events outrank a software write in the same cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      status_word <= STATUS_RESET;
    end else if (is_trap) begin
      status_word[STAT_EP] <= 1'b1;
      status_word[STAT_ID] <= 1'b1;
    end else if (dbg_entry) begin
      status_word[STAT_NP] <= 1'b1;
      status_word[STAT_EP] <= 1'b1;
      status_word[STAT_ID] <= 1'b1;
    end else if (is_exc_return_instr) begin
      status_word <= exc_saved_status;
    end else if (is_debug_return_instr) begin
      status_word <= dbg_saved_status;
    end else if (irq_fire) begin
      status_word[STAT_ID] <= 1'b1;
    end else if (wr_en && avs_byteenable[0] && avs_address == OFF_STATUS) begin
      status_word <= avs_writedata[STAT_W-1:0];
    end
  end

  // exception save set; shared by traps and maskable entry
  always_ff @(posedge clock) begin
    if (rst) begin
      exc_return_pc    <= 32'h0000_0000;
      exc_saved_status <= 8'h00;
      exc_cause_reg    <= 32'h0000_0000;
    end else if (is_trap || irq_fire) begin
      exc_return_pc    <= issue.return_pc;
      exc_saved_status <= status_word;
      exc_cause_reg    <= {16'h0000, is_trap ? TRAP_CODE_BASE + {11'h000, issue.vector}
                                             : IRQ_CODE_BASE + {14'h0000, best_idx}};
    end else if (wr_en) begin
      if (avs_address == OFF_EXC_PC) begin
        exc_return_pc <= be_merge(exc_return_pc, avs_writedata, avs_byteenable);
      end
      if (avs_address == OFF_EXC_STAT && avs_byteenable[0]) begin
        exc_saved_status <= avs_writedata[STAT_W-1:0];
      end
      if (avs_address == OFF_EXC_CAUSE) begin
        exc_cause_reg <= be_merge(exc_cause_reg, avs_writedata, avs_byteenable);
      end
    end
  end

  // debug save set; software sees it only inside the debug window
  always_ff @(posedge clock) begin
    if (rst) begin
      dbg_return_pc    <= 32'h0000_0000;
      dbg_saved_status <= 8'h00;
    end else if (dbg_entry) begin
      dbg_return_pc    <= issue.return_pc;
      dbg_saved_status <= status_word;
    end else if (wr_en && dbg_window_reg) begin
      if (avs_address == OFF_DBG_PC) begin
        dbg_return_pc <= be_merge(dbg_return_pc, avs_writedata, avs_byteenable);
      end
      if (avs_address == OFF_DBG_STAT && avs_byteenable[0]) begin
        dbg_saved_status <= avs_writedata[STAT_W-1:0];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      dbg_window_reg <= 1'b0;
    end else if (dbg_entry) begin
      dbg_window_reg <= 1'b1;
    end else if (is_debug_return_instr) begin
      dbg_window_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // redirect to the pipeline, one cycle after the event
  // ------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      redirect <= '0;
    end else begin
      redirect.valid <= exc_event || irq_fire;
      redirect.flush <= exc_event || irq_fire;
      if (is_trap) begin
        redirect.pc <= issue.vector[4] ? VEC_TRAP_HI : VEC_TRAP_LO;
      end else if (dbg_entry) begin
        redirect.pc <= VEC_DEBUG;
      end else if (is_exc_return_instr) begin
        redirect.pc <= exc_return_pc;
      end else if (is_debug_return_instr) begin
        redirect.pc <= dbg_return_pc;
      end else if (irq_fire) begin
        redirect.pc <= VEC_IRQ_BASE + {26'h0, best_idx, 4'h0};
      end
    end
  end

  // ------------------------------------------------------------------
  // avalon slave, one wait state on every access
  // ------------------------------------------------------------------
  logic [31:0] rd_mux;

  assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;

  always_ff @(posedge clock) begin
    if (rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read || avs_write) && !ack_reg;
    end
  end

  // unmapped offsets and a closed debug window read as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (avs_address)
      OFF_STATUS:    rd_mux = {24'h0, status_word};
      OFF_EXC_PC:    rd_mux = exc_return_pc;
      OFF_EXC_STAT:  rd_mux = {24'h0, exc_saved_status};
      OFF_EXC_CAUSE: rd_mux = exc_cause_reg;
      OFF_DBG_PC:    rd_mux = dbg_window_reg ? dbg_return_pc : 32'h0;
      OFF_DBG_STAT:  rd_mux = dbg_window_reg ? {24'h0, dbg_saved_status} : 32'h0;
      OFF_IRQ_STATE: rd_mux = {16'h0, 4'(slot_pend), isr_reg, 3'h0, dbg_window_reg};
      default: begin
        for (int i = 0; i < NUM_IRQ; i++) begin
          if (avs_address == OFF_IRQ_CTRL0 + 8'(4 * i)) begin
            rd_mux = {24'h0, slot_pend[i], slot_mask[i], 3'h0, slot_prio[i]};
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack_reg) begin
      avs_readdata <= rd_mux;
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  chk_trap_vector_flush: assert property (is_trap |=> redirect.valid && redirect.flush &&
      redirect.pc == ($past(issue.vector[4]) ? 32'h0000_0050 : 32'h0000_0040))
    else $error("software exception did not vector correctly");
  chk_trap_save_state: assert property (is_trap |=> exc_return_pc == $past(issue.return_pc) &&
      exc_saved_status == $past(status_word))
    else $error("software exception did not save pc and status");
  chk_trap_code_field: assert property (is_trap |=> exc_cause_reg[15:0] ==
      16'h0040 + {11'h0, $past(issue.vector)})
    else $error("exception code does not follow the vector");
  chk_trap_flag_set: assert property (is_trap |=> status_word[STAT_EP] && status_word[STAT_ID])
    else $error("exception entry flags not set");
  chk_exc_return_instr_restore: assert property (is_exc_return_instr |=> status_word == $past(exc_saved_status) &&
      redirect.pc == $past(exc_return_pc))
    else $error("exception return did not restore");
  chk_debug_entry: assert property (dbg_entry |=> redirect.pc == 32'h0000_0060 &&
      status_word[2:0] == 3'h7 && dbg_return_pc == $past(issue.return_pc) && dbg_window_reg)
    else $error("debug trap entry wrong");
  chk_debug_return: assert property (is_debug_return_instr |=> status_word == $past(dbg_saved_status) &&
      redirect.pc == $past(dbg_return_pc) && !dbg_window_reg)
    else $error("debug return did not restore");
  chk_debug_gate: assert property (avs_read && !ack_reg && !dbg_window_reg &&
      avs_address == OFF_DBG_PC |=> avs_readdata == 32'h0)
    else $error("debug save register visible outside window");
  chk_nest_gate: assert property (irq_fire |-> !status_word[STAT_ID] && !status_word[STAT_NP] &&
      !shadow_reg && best_prio < cur_level)
    else $error("maskable request acknowledged while blocked");
  chk_isr_pop: assert property (is_exc_return_instr && !status_word[STAT_EP] |=>
      isr_reg == ($past(isr_reg) & ($past(isr_reg) - 8'h01)))
    else $error("return did not end innermost service");
  chk_latency_min: assert property (irq_fire |-> $past(eligible, 1) && $past(eligible, 2) &&
      $past(eligible, 3))
    else $error("interrupt taken sooner than four cycles");
  chk_latency_long: assert property (irq_fire && long_seen_reg |-> lat_cnt_reg == 3'h5)
    else $error("long instruction latency not at the maximum");

  cov_trap_taken: cover property (is_trap ##1 redirect.valid);
  cov_nested_irq: cover property (irq_fire && isr_reg != 8'h00);
  cov_debug_round: cover property (dbg_entry ##[1:20] is_debug_return_instr);
  cov_long_latency: cover property (irq_fire && long_seen_reg);

endmodule // etc_trap_ctrl

// File: etc_pipe_model.sv
// stand-in for the instruction pipeline: issues commanded instructions, logs redirects
`timescale 1ns/1ps
module etc_pipe_model
  import etc_pkg::*;
(
  input  logic          clock,
  input  logic          rst,
  input  logic          go,
  input  etc_issue_s    cmd,
  output etc_issue_s    issue,
  input  etc_redirect_s redirect,
  output logic [31:0]   last_pc,
  output logic [7:0]    rd_cnt
);
  // one instruction per command; idle cycles carry zero so nothing stale executes
  always_ff @(posedge clock) begin
    issue <= (go && !rst) ? cmd : '0;
  end
  // a flush restarts fetch at redirect.pc, the pipe only remembers where
  always_ff @(posedge clock) begin
    if (rst) begin
      rd_cnt  <= 8'h00;
      last_pc <= 32'h0;
    end else if (redirect.valid) begin
      rd_cnt  <= rd_cnt + 8'h01;
      last_pc <= redirect.pc;
    end
  end
endmodule // etc_pipe_model

// File: tb.sv
// self-checking bench for the exception and trap sequencer
`timescale 1ns/1ps
module tb;
  import etc_pkg::*;
  logic               clock, rst, go, avs_read, avs_write, avs_waitrequest;
  logic [NUM_IRQ-1:0] irq_req;
  logic [7:0]         avs_address, rd_cnt, stat, status_word;
  logic [31:0]        avs_writedata, avs_readdata, last_pc, rd;
  etc_issue_s         cmd, issue;
  etc_redirect_s      redirect;
  int                 failures, comparisons, n;

  etc_trap_ctrl dut_u (.clock(clock), .rst(rst), .issue(issue), .irq_req(irq_req),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .redirect(redirect), .status_word(status_word));
  etc_pipe_model pipe_u (.clock(clock), .rst(rst), .go(go), .cmd(cmd), .issue(issue),
    .redirect(redirect), .last_pc(last_pc), .rd_cnt(rd_cnt));

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // request held until waitrequest is seen low, released after that edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic instr(input etc_kind_e k, input logic [4:0] v, input logic [31:0] w,
                       input logic [31:0] p);
    logic [7:0] c0;
    c0 = rd_cnt;
    @(posedge clock);
    cmd <= '{1'b1, k, v, w, p, 1'b0, 1'b0};
    go  <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    n = 0;
    // returns at the negedge just after the redirect pulse has ended
    while (rd_cnt == c0 && n < 20) begin
      @(negedge clock);
      n++;
    end
  endtask
  // rising edges from the reference edge to the entry pulse; start at the negedge after it
  task automatic wait_rd;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (redirect.valid !== 1'b1 && n < 10);
  endtask
  task automatic test_done;
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // clock, watchdog, tests
  // ------------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #(CLK_PERIOD_NS / 2) clock = ~clock;
  end
  initial begin
    repeat (5000) @(posedge clock);
    failures++;
    test_done;
  end
  initial begin
    {rst, go, avs_read, avs_write, irq_req, avs_address, avs_writedata} = '0;
    rst = 1'b1;
    cmd = '0;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    bus(0, OFF_IRQ_CTRL0, 0); check(rd, 32'h47);
    bus(0, 8'hfc, 0); check(rd, 0);
    bus(0, OFF_DBG_PC, 0); check(rd, 0);
    // both vector halves; the second trap runs with EP already set
    for (int v = 5; v < 32; v += 16) begin
      stat = status_word;
      instr(ETC_K_TRAP, v[4:0], 0, 32'h1000 + v);
      check(last_pc, v < 16 ? VEC_TRAP_LO : VEC_TRAP_HI);
      bus(0, OFF_EXC_PC, 0); check(rd, 32'h1000 + v);
      bus(0, OFF_EXC_STAT, 0); check(rd, {24'h0, stat});
      bus(0, OFF_EXC_CAUSE, 0); check(rd[15:0], TRAP_CODE_BASE + v);
      check(status_word, stat | 8'h03);
    end
    bus(1, OFF_EXC_STAT, 0); // software clears saved status to zero
    instr(ETC_K_EXC_RETURN_INSTR, 0, 0, 0);
    check(last_pc, 32'h1015);
    check(status_word, 0);
    // debug break, then illegal opcode with kind none
    for (int i = 0; i < 2; i++) begin
      instr(i ? ETC_K_NONE : ETC_K_DEBUG_BREAK_INSTR, 0, i ? 32'h0380_07e0 : 0, 32'h2000 + i);
      check(last_pc, VEC_DEBUG);
      check(status_word, 8'h07);
      bus(0, OFF_DBG_PC, 0); check(rd, 32'h2000 + i);
      instr(ETC_K_DEBUG_RETURN_INSTR, 0, 0, 0);
      check(last_pc, 32'h2000 + i);
      check(status_word, 0);
      bus(0, OFF_DBG_PC, 0); check(rd, 0);
    end
    stat = rd_cnt;
    instr(ETC_K_NONE, 0, 32'h0381_07e0, 0); // bit 16 set: legal
    check(rd_cnt, stat);
    bus(1, OFF_IRQ_CTRL0, 32'h02);
    bus(1, OFF_IRQ_CTRL0 + 8'h04, 32'h01);
    @(posedge clock);
    irq_req <= 4'h1;
    @(posedge clock);
    irq_req <= 4'h0;
    @(negedge clock);
    wait_rd;
    check(n, 4);
    check(redirect.pc, VEC_IRQ_BASE);
    check(status_word[0], 1'b1);
    // ID set inside the routine: even a better request must wait
    @(posedge clock);
    irq_req <= 4'h2;
    @(posedge clock);
    irq_req <= 4'h0;
    stat = rd_cnt; // entry pulse already counted by now
    repeat (8) @(posedge clock);
    check(rd_cnt, stat);
    bus(0, OFF_IRQ_CTRL0 + 8'h04, 0); check(rd, 32'h81);
    instr(ETC_K_EXC_RETURN_INSTR, 0, 0, 0);
    wait_rd;
    check(n, 4);
    check(redirect.pc, VEC_IRQ_BASE + 32'h10);
    // nested entry at level 0 over level 1, a long instruction in flight
    bus(1, OFF_IRQ_CTRL0, 32'h00);
    bus(1, OFF_STATUS, 32'h00);
    @(posedge clock);
    irq_req <= 4'h1;
    cmd     <= '{1'b1, ETC_K_NONE, 5'h00, 32'h0, 32'h0, 1'b1, 1'b0};
    go      <= 1'b1;
    @(posedge clock);
    irq_req <= 4'h0;
    go      <= 1'b0;
    @(negedge clock);
    wait_rd;
    check(n, LAT_MAX_CYC);
    check(redirect.pc, VEC_IRQ_BASE);
    test_done;
  end
endmodule // tb
